// ===== pkg/rac_map.svh
/*
 * Address map, register layout and reset constants of the register access block.
 * Assumes it is included by its bare name from the package and the design modules.
 */
`ifndef RAC_MAP_SVH
`define RAC_MAP_SVH

// Register address space and byte geometry
`define RAC_ADDR_W 16
`define RAC_ADDR_FIRST 16'h0000
`define RAC_ADDR_LAST 16'h0E3C
`define RAC_BYTE_W 8
`define RAC_BYTE_RST 8'h00
`define RAC_BYTE_ZERO 8'h00

// Update trigger register and its commit command
`define RAC_UPD_ADDR 16'h0005
`define RAC_UPD_CMD 8'h01

// Buffered regular block
`define RAC_BUF_BASE 16'h0100
`define RAC_BUF_LAST 16'h010F
`define RAC_BUF_N 16

// Live block, kept out of the non-volatile image
`define RAC_LIVE_BASE 16'h0A00
`define RAC_LIVE_LAST 16'h0A03
`define RAC_LIVE_N 4

// Read-only status block
`define RAC_RO_BASE 16'h0D00
`define RAC_RO_LAST 16'h0D03
`define RAC_RO_N 4

// Autoclear action register
`define RAC_AC_ADDR 16'h0E00

// Non-volatile storage sequence block
`define RAC_SEQ_BASE 16'h0E10
`define RAC_SEQ_LAST 16'h0E3C
`define RAC_SEQ_N 45

// Storage index layout: buffered, live, autoclear, sequence
`define RAC_IDX_W 7
`define RAC_IDX_BUF 7'h00
`define RAC_IDX_LIVE 7'h10
`define RAC_IDX_AC 7'h14
`define RAC_IDX_SEQ 7'h15
`define RAC_NW 66

`endif

// ===== pkg/rac_pkg.sv
/*
 * Types shared by the register access block.
 * Assumes rac_map.svh sits on the include path.
 */
`include "rac_map.svh"

package rac_pkg;

   // Position of the next received byte inside a serial write transfer
   typedef enum logic [1:0] {
      PH_ADDR_HI,
      PH_ADDR_LO,
      PH_DATA
   } rac_phase_t;

endpackage

// ===== src/rac_attr_dec.sv
/*
 * Address decoder: turns a register address into a storage index and attribute set.
 * Assumes a purely combinational use; one copy per access source.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rac_map.svh"

module rac_attr_dec (
   input wire logic [`RAC_ADDR_W-1:0] addr_in, // Register address
   output logic hit_out, // Address holds a register
   output logic [`RAC_IDX_W-1:0] idx_out, // Storage or status index
   output logic ro_out, // Read-only attribute
   output logic live_out, // Live attribute, bypasses buffering
   output logic ac_out, // Autoclear attribute
   output logic excl_out, // Kept out of non-volatile image
   output logic upd_out // Address is the update trigger
);

   // Fixed attribute table per address region; unlisted addresses miss
   always_comb begin
      hit_out = 1'b0;
      idx_out = `RAC_IDX_BUF;
      ro_out = 1'b0;
      live_out = 1'b0;
      ac_out = 1'b0;
      excl_out = 1'b0;
      upd_out = 1'b0;
      if (addr_in == `RAC_UPD_ADDR) begin
         // Trigger acts the moment it lands and clears itself
         hit_out = 1'b1;
         live_out = 1'b1;
         ac_out = 1'b1;
         excl_out = 1'b1;
         upd_out = 1'b1;
      end else if (addr_in >= `RAC_BUF_BASE && addr_in <= `RAC_BUF_LAST) begin
         hit_out = 1'b1;
         idx_out = `RAC_IDX_BUF + `RAC_IDX_W'(addr_in - `RAC_BUF_BASE);
      end else if (addr_in >= `RAC_LIVE_BASE && addr_in <= `RAC_LIVE_LAST) begin
         hit_out = 1'b1;
         idx_out = `RAC_IDX_LIVE + `RAC_IDX_W'(addr_in - `RAC_LIVE_BASE);
         live_out = 1'b1;
         excl_out = 1'b1;
      end else if (addr_in >= `RAC_RO_BASE && addr_in <= `RAC_RO_LAST) begin
         // Index here selects a status byte, not storage
         hit_out = 1'b1;
         idx_out = `RAC_IDX_W'(addr_in - `RAC_RO_BASE);
         ro_out = 1'b1;
      end else if (addr_in == `RAC_AC_ADDR) begin
         hit_out = 1'b1;
         idx_out = `RAC_IDX_AC;
         ac_out = 1'b1;
      end else if (addr_in >= `RAC_SEQ_BASE && addr_in <= `RAC_SEQ_LAST) begin
         // Sequence bytes are opaque, not a little-endian parameter
         hit_out = 1'b1;
         idx_out = `RAC_IDX_SEQ + `RAC_IDX_W'(addr_in - `RAC_SEQ_BASE);
         excl_out = 1'b1;
      end
   end

endmodule
`default_nettype wire

// ===== src/rac_access_arb.sv
/*
 * Access arbiter between the serial port and the non-volatile memory controller.
 * Assumes attributes come from rac_attr_dec; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module rac_access_arb (
   input wire logic ee_busy_in, // Controller in load or store mode
   input wire logic h_hit_in, // Host address holds a register
   input wire logic h_ro_in, // Host address is read-only
   input wire logic e_hit_in, // Controller address holds a register
   input wire logic e_ro_in, // Controller address is read-only
   input wire logic e_excl_in, // Controller address excluded
   input wire logic e_upd_in, // Controller address is the trigger
   output logic h_rd_ok_out, // Host read allowed
   output logic h_wr_ok_out, // Host write allowed
   output logic e_ok_out // Controller access allowed
);

   // Every category must allow the access, so the strictest one governs
   always_comb begin
      // Read-only bytes stay visible even while the controller owns the map
      h_rd_ok_out = h_hit_in && (h_ro_in || !ee_busy_in);
      // Controller ownership locks the host out of regular bytes
      h_wr_ok_out = h_hit_in && !h_ro_in && !ee_busy_in;
      // Controller never touches read-only, excluded or trigger bytes
      e_ok_out = ee_busy_in && e_hit_in && !e_ro_in && !e_excl_in && !e_upd_in;
   end

endmodule
`default_nettype wire

// ===== src/rac_regbank.sv
/*
 * Register bank with buffered and active copies, live and autoclear bytes,
 * a serial-port byte sequencer and an access port for the non-volatile controller.
 * Assumes an external serial front end that strips the slave address and delivers
 * whole bytes, start and stop as one-cycle pulses synchronous to clock_in.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rac_map.svh"

// What this block does
// - Decode 0x0000-0x0E3C, one byte per address
// - Multi-byte values: LSB at lowest address D0
// - Storage sequence bytes skip that byte ordering
// - Writing 0x01 to 0x0005 commits buffered values
// - Live bytes act when their byte lands
// - Autoclear bits cleared when action completes
// - Strictest of several access categories applies
// - Denied reads give zero, writes dropped
// - Missing addresses act like denied ones
// - Controller busy gives it exclusive regular access
// - Read-only bytes always readable by host
// - Excluded and read-only bytes skip controller
// - Two address bytes high first, then data
module rac_regbank (
   input wire logic clock_in, // System clock, 20 MHz
   input wire logic srst_in, // Synchronous reset, active high
   input wire logic hs_start_in, // Start or repeated start seen, pulse
   input wire logic hs_stop_in, // Stop seen, pulse
   input wire logic hs_read_mode_in, // Current transfer reads from device
   input wire logic hs_rx_valid_in, // Received byte strobe, pulse
   input wire logic [7:0] hs_rx_byte_in, // Received byte
   input wire logic hs_tx_pop_in, // Master took tx byte and wants next, pulse
   output logic [7:0] hs_tx_byte_out, // Byte to send in read mode
   input wire logic ee_busy_in, // Controller in load or store mode
   input wire logic ee_req_in, // Controller access request, pulse
   input wire logic ee_we_in, // Controller request is a write
   input wire logic [`RAC_ADDR_W-1:0] ee_addr_in, // Controller address
   input wire logic [7:0] ee_wdata_in, // Controller write data
   output logic [7:0] ee_rdata_out, // Controller read data
   output logic ee_ack_out, // Controller request answered, pulse
   input wire logic [`RAC_RO_N*8-1:0] status_in, // Device state shown read-only
   input wire logic [7:0] action_done_in, // Per-bit completion of autoclear actions
   output logic [`RAC_NW*8-1:0] active_cfg_out, // Active copies, byte i at bits 8i+7:8i
   output logic io_update_out // Commit happened, pulse
);

   // Serial sequencer state
   rac_pkg::rac_phase_t phase_ff; // Position within a write transfer
   rac_pkg::rac_phase_t nxt_phase;
   logic [`RAC_ADDR_W-1:0] ptr_ff; // Current register address
   logic [`RAC_ADDR_W-1:0] nxt_ptr;
   logic [7:0] tx_ff; // Read data staged for the front end
   logic [7:0] nxt_tx;
   logic host_wr; // A data byte arrived in write mode

   // Storage state
   logic [7:0] buf_ff [`RAC_NW]; // Buffered copies, what software wrote
   logic [7:0] nxt_buf [`RAC_NW];
   logic [7:0] act_ff [`RAC_NW]; // Active copies, what the device uses
   logic [7:0] nxt_act [`RAC_NW];
   logic upd_ff; // Commit pulse register
   logic nxt_upd;
   logic [7:0] ee_rdata_ff; // Controller read data register
   logic [7:0] nxt_ee_rdata;
   logic ee_ack_ff; // Controller answer pulse register
   logic nxt_ee_ack;

   // Decoded attributes of the host pointer
   logic h_hit;
   logic [`RAC_IDX_W-1:0] h_idx;
   logic h_ro;
   logic h_live;
   logic h_upd;
   // Decoded attributes of the controller address
   logic e_hit;
   logic [`RAC_IDX_W-1:0] e_idx;
   logic e_ro;
   logic e_live;
   logic e_excl;
   logic e_upd;
   // Arbiter verdicts
   logic h_rd_ok;
   logic h_wr_ok;
   logic e_ok;
   logic commit; // Valid trigger write this cycle

   // Host pointer decode; excluded and autoclear flags do not matter to the host
   rac_attr_dec u_host_dec (
      .addr_in(ptr_ff),
      .hit_out(h_hit),
      .idx_out(h_idx),
      .ro_out(h_ro),
      .live_out(h_live),
      .ac_out(),
      .excl_out(),
      .upd_out(h_upd)
   );

   // Controller address decode
   rac_attr_dec u_ee_dec (
      .addr_in(ee_addr_in),
      .hit_out(e_hit),
      .idx_out(e_idx),
      .ro_out(e_ro),
      .live_out(e_live),
      .ac_out(),
      .excl_out(e_excl),
      .upd_out(e_upd)
   );

   // Ownership and permission for both sources
   rac_access_arb u_arb (
      .ee_busy_in(ee_busy_in),
      .h_hit_in(h_hit),
      .h_ro_in(h_ro),
      .e_hit_in(e_hit),
      .e_ro_in(e_ro),
      .e_excl_in(e_excl),
      .e_upd_in(e_upd),
      .h_rd_ok_out(h_rd_ok),
      .h_wr_ok_out(h_wr_ok),
      .e_ok_out(e_ok)
   );

   // Serial sequencer: address bytes, then data with auto-increment
   always_comb begin
      nxt_phase = phase_ff;
      nxt_ptr = ptr_ff;
      host_wr = 1'b0;
      if (hs_start_in || hs_stop_in) begin
         // Any start or stop drops a partial transfer; pointer survives for reads
         nxt_phase = rac_pkg::PH_ADDR_HI;
      end else if (hs_rx_valid_in && !hs_read_mode_in) begin
         case (phase_ff)
            rac_pkg::PH_ADDR_HI: begin
               nxt_ptr = {hs_rx_byte_in, ptr_ff[7:0]};
               nxt_phase = rac_pkg::PH_ADDR_LO;
            end
            rac_pkg::PH_ADDR_LO: begin
               nxt_ptr = {ptr_ff[15:8], hs_rx_byte_in};
               nxt_phase = rac_pkg::PH_DATA;
            end
            rac_pkg::PH_DATA: begin
               // Each data byte lands at the pointer, which then steps on
               host_wr = 1'b1;
               nxt_ptr = ptr_ff + 16'h0001;
            end
            default: begin
               nxt_phase = rac_pkg::PH_ADDR_HI;
            end
         endcase
      end else if (hs_tx_pop_in && hs_read_mode_in) begin
         nxt_ptr = ptr_ff + 16'h0001;
      end
   end

   // Read path for the host: tracks the pointer every cycle
   always_comb begin
      nxt_tx = `RAC_BYTE_ZERO;
      if (!h_rd_ok) begin
         // Denied or missing byte reads as zero
         nxt_tx = `RAC_BYTE_ZERO;
      end else if (h_ro) begin
         nxt_tx = status_in[h_idx[1:0]*8 +: 8];
      end else if (h_upd) begin
         // Trigger has always finished by the time it could be read
         nxt_tx = `RAC_BYTE_ZERO;
      end else if (h_live) begin
         nxt_tx = act_ff[h_idx];
      end else begin
         // Buffered bytes read back what was written, committed or not
         nxt_tx = buf_ff[h_idx];
      end
   end

   // A trigger write counts only with the exact command and host ownership
   assign commit = host_wr && h_wr_ok && h_upd && (hs_rx_byte_in == `RAC_UPD_CMD);

   // Storage next state: autoclear, commit, then writes from either source
   always_comb begin
      nxt_buf = buf_ff;
      nxt_act = act_ff;
      // Completed actions clear their bits in both copies
      nxt_buf[`RAC_IDX_AC] = buf_ff[`RAC_IDX_AC] & ~action_done_in;
      nxt_act[`RAC_IDX_AC] = act_ff[`RAC_IDX_AC] & ~action_done_in;
      // Commit copies every non-live byte; placed after the clear so a
      // request committed in the same cycle as a completion is not lost
      if (commit) begin
         for (int i = 0; i < `RAC_NW; i++) begin
            if (i < `RAC_IDX_LIVE || i >= `RAC_IDX_AC) begin
               nxt_act[i] = buf_ff[i];
            end
         end
      end
      // Host writes; denied and missing addresses fall through untouched
      if (host_wr && h_wr_ok && !h_upd) begin
         nxt_buf[h_idx] = hs_rx_byte_in;
         if (h_live) begin
            nxt_act[h_idx] = hs_rx_byte_in;
         end
      end
      // Controller loads; only while it owns the map, never at the same time
      // as a host write, since host write permission requires it idle
      if (ee_req_in && ee_we_in && e_ok) begin
         nxt_buf[e_idx] = ee_wdata_in;
         if (e_live) begin
            nxt_act[e_idx] = ee_wdata_in;
         end
      end
   end

   // Controller read path and answer pulse
   always_comb begin
      nxt_ee_ack = ee_req_in;
      nxt_ee_rdata = `RAC_BYTE_ZERO;
      if (ee_req_in && !ee_we_in && e_ok) begin
         nxt_ee_rdata = e_live ? act_ff[e_idx] : buf_ff[e_idx];
      end
      nxt_upd = commit;
   end

   // Sequencer registers
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         phase_ff <= rac_pkg::PH_ADDR_HI;
         ptr_ff <= `RAC_ADDR_FIRST;
         tx_ff <= `RAC_BYTE_RST;
      end else begin
         phase_ff <= nxt_phase;
         ptr_ff <= nxt_ptr;
         tx_ff <= nxt_tx;
      end
   end

   // Storage and controller registers
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         for (int i = 0; i < `RAC_NW; i++) begin
            buf_ff[i] <= `RAC_BYTE_RST;
            act_ff[i] <= `RAC_BYTE_RST;
         end
         upd_ff <= 1'b0;
         ee_rdata_ff <= `RAC_BYTE_RST;
         ee_ack_ff <= 1'b0;
      end else begin
         for (int i = 0; i < `RAC_NW; i++) begin
            buf_ff[i] <= nxt_buf[i];
            act_ff[i] <= nxt_act[i];
         end
         upd_ff <= nxt_upd;
         ee_rdata_ff <= nxt_ee_rdata;
         ee_ack_ff <= nxt_ee_ack;
      end
   end

   // Active copies laid out so multi-byte values read little-endian
   for (genvar g = 0; g < `RAC_NW; g++) begin : g_pack
      assign active_cfg_out[g*8 +: 8] = act_ff[g];
   end

   assign hs_tx_byte_out = tx_ff;
   assign ee_rdata_out = ee_rdata_ff;
   assign ee_ack_out = ee_ack_ff;
   assign io_update_out = upd_ff;

endmodule
`default_nettype wire

// ===== testbench/rac_regbank_sva.sv
/* Port checker for the register bank.
   Assumes one clock domain and a bind onto rac_regbank. */
`timescale 1ns/1ps
`default_nettype none
`include "rac_map.svh"
module rac_regbank_chk (
   input wire logic clock_in, // Clock
   input wire logic srst_in, // Sync reset
   input wire logic hs_read_mode_in, // Read transfer
   input wire logic hs_rx_valid_in, // Byte strobe
   input wire logic [7:0] hs_rx_byte_in, // Received byte
   input wire logic ee_busy_in, // Controller busy
   input wire logic ee_req_in, // Controller request
   input wire logic ee_we_in, // Controller write
   input wire logic [`RAC_ADDR_W-1:0] ee_addr_in, // Controller address
   input wire logic [7:0] action_done_in, // Action completion
   input wire logic [7:0] ee_rdata_out, // Controller data
   input wire logic ee_ack_out, // Controller answer
   input wire logic [`RAC_NW*8-1:0] active_cfg_out, // Active copies
   input wire logic io_update_out // Commit pulse
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (srst_in);
   // Commit command byte as the front end delivers it in a write
   wire logic cmd_byte = hs_rx_valid_in && !hs_read_mode_in && hs_rx_byte_in == `RAC_UPD_CMD;
   // Controller handshake steps
   sequence s_take;
      ee_req_in;
   endsequence
   sequence s_answer;
      ee_ack_out;
   endsequence
   // Controller requests aimed at bytes it may never reach
   sequence s_take_seq;
      ee_req_in && ee_addr_in inside {[`RAC_SEQ_BASE:`RAC_SEQ_LAST]};
   endsequence
   sequence s_take_ro;
      ee_req_in && ee_addr_in inside {[`RAC_RO_BASE:`RAC_RO_LAST]};
   endsequence
   sequence s_take_live;
      ee_req_in && ee_addr_in inside {[`RAC_LIVE_BASE:`RAC_LIVE_LAST]};
   endsequence
   // No completion and no host byte in the cycle before
   sequence s_quiet;
      $past(action_done_in) == 8'h00 && !$past(hs_rx_valid_in);
   endsequence
   AST_EE_ACK: assert property (s_take |=> s_answer)
      else $error("controller request not answered");
   AST_EE_NOREQ: assert property (!ee_req_in |=> !ee_ack_out)
      else $error("answer without request");
   AST_EE_IDLE: assert property (s_take ##0 !ee_busy_in |=> ee_rdata_out == 8'h00)
      else $error("controller read while idle not zero");
   AST_EE_SEQ: assert property (s_take_seq |=> ee_rdata_out == 8'h00)
      else $error("excluded sequence byte reached controller");
   AST_EE_RO: assert property (s_take_ro |=> ee_rdata_out == 8'h00)
      else $error("read-only byte reached controller");
   AST_EE_LIVE: assert property (s_take_live |=> ee_rdata_out == 8'h00)
      else $error("excluded live byte reached controller");
   // A commit only follows a received command byte
   AST_COMMIT: assert property (io_update_out |-> $past(cmd_byte))
      else $error("commit without command byte");
   // Active copies move only on a host byte or an action completion
   AST_HOLD: assert property (s_quiet |-> $stable(active_cfg_out))
      else $error("active copy changed without cause");
endmodule
bind rac_regbank rac_regbank_chk u_rac_regbank_chk (.clock_in, .srst_in, .hs_read_mode_in,
   .hs_rx_valid_in, .hs_rx_byte_in, .ee_busy_in, .ee_req_in, .ee_we_in, .ee_addr_in,
   .action_done_in, .ee_rdata_out, .ee_ack_out, .active_cfg_out, .io_update_out);
`default_nettype wire

// ===== testbench/rac_host_model.sv
/* Serial port master seen through the byte front end.
   Assumes inputs change at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module rac_host_model (
   input wire logic clock_in, // System clock
   input wire logic [7:0] hs_tx_byte_in, // Byte from device
   output var logic hs_start_out, // Start pulse
   output var logic hs_stop_out, // Stop pulse
   output var logic hs_read_mode_out, // Read transfer
   output var logic hs_rx_valid_out, // Byte strobe
   output var logic [7:0] hs_rx_byte_out, // Byte to device
   output var logic hs_tx_pop_out // Next byte request
);
   initial begin
      {hs_start_out, hs_stop_out, hs_read_mode_out, hs_rx_valid_out, hs_tx_pop_out} = 5'h00;
      hs_rx_byte_out = 8'hFF;
   end
   task automatic start(input logic rd);
      @(negedge clock_in);
      hs_start_out = 1'b1;
      hs_read_mode_out = rd;
      @(negedge clock_in);
      hs_start_out = 1'b0;
   endtask
   // Released byte lines show the inverse so stale data cannot pass
   task automatic send(input logic [7:0] b);
      @(negedge clock_in);
      hs_rx_valid_out = 1'b1;
      hs_rx_byte_out = b;
      @(negedge clock_in);
      hs_rx_valid_out = 1'b0;
      hs_rx_byte_out = ~b;
   endtask
   task automatic stop();
      @(negedge clock_in);
      hs_stop_out = 1'b1;
      @(negedge clock_in);
      hs_stop_out = 1'b0;
      hs_read_mode_out = 1'b0;
   endtask
   // Address high byte first, then low byte
   task automatic set_ptr(input logic [15:0] a);
      start(1'b0);
      send(a[15:8]);
      send(a[7:0]);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      set_ptr(a);
      send(d);
      stop();
   endtask
   // Group of two bytes, low byte at the lower address, one commit later
   task automatic wr16(input logic [15:0] a, input logic [15:0] d);
      set_ptr(a);
      send(d[7:0]);
      send(d[15:8]);
      stop();
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      set_ptr(a);
      stop();
      start(1'b1);
      repeat (3) @(negedge clock_in);
      d = hs_tx_byte_in;
      stop();
   endtask
   // Two-byte burst read; the pop steps the pointer, the staged byte follows later
   task automatic rd2(input logic [15:0] a, output logic [15:0] d);
      set_ptr(a);
      stop();
      start(1'b1);
      repeat (3) @(negedge clock_in);
      d[7:0] = hs_tx_byte_in;
      hs_tx_pop_out = 1'b1;
      @(negedge clock_in);
      hs_tx_pop_out = 1'b0;
      repeat (2) @(negedge clock_in);
      d[15:8] = hs_tx_byte_in;
      stop();
   endtask
endmodule
`default_nettype wire

// ===== testbench/tb_rac_regbank.sv
/* Self-checking bench for the register bank.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "rac_map.svh"
module tb_rac_regbank;
   logic clock_in = 1'b0; // 20 MHz clock
   logic srst_in = 1'b1; // Reset
   logic ee_busy = 1'b0, ee_req = 1'b0, ee_we = 1'b0; // Controller side
   logic [15:0] ee_addr = 16'h0000; // Controller address
   logic [7:0] ee_wdata = 8'h00, done = 8'h00, q; // Data, completion, read value
   logic [31:0] status = 32'h0000_0000; // Status bytes
   wire logic st, sp, rm, rv, pop, ack, upd; // Handshake lines
   wire logic [7:0] rb, tb, erd; // Byte lines
   wire logic [`RAC_NW*8-1:0] act; // Active copies
   int fails = 0, n_compared = 0; // Counters
   int n_upd = 0; // Commit pulses seen
   logic [15:0] w; // Burst read value
   logic [15:0] holes [3] = '{16'h0E3D, 16'h0200, 16'h0004}; // Unmapped addresses
   logic [15:0] shut [4] = '{16'h0D00, 16'h0A00, 16'h0E3C, 16'h0005}; // Closed to controller
   // Commit pulse lasts one cycle, so it is counted at the falling edge
   always @(negedge clock_in) if (upd === 1'b1) n_upd++;
   always #25 clock_in = ~clock_in;
   rac_host_model u_rac_host_model (.clock_in(clock_in), .hs_tx_byte_in(tb),
      .hs_start_out(st), .hs_stop_out(sp), .hs_read_mode_out(rm), .hs_rx_valid_out(rv),
      .hs_rx_byte_out(rb), .hs_tx_pop_out(pop));
   rac_regbank u_rac_regbank (.clock_in(clock_in), .srst_in(srst_in), .hs_start_in(st),
      .hs_stop_in(sp), .hs_read_mode_in(rm), .hs_rx_valid_in(rv), .hs_rx_byte_in(rb),
      .hs_tx_pop_in(pop), .hs_tx_byte_out(tb), .ee_busy_in(ee_busy), .ee_req_in(ee_req),
      .ee_we_in(ee_we), .ee_addr_in(ee_addr), .ee_wdata_in(ee_wdata), .ee_rdata_out(erd),
      .ee_ack_out(ack), .status_in(status), .action_done_in(done), .active_cfg_out(act),
      .io_update_out(upd));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      if (fails == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // One controller access; the answer is due exactly one cycle later
   task automatic ee(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(negedge clock_in);
      {ee_req, ee_we, ee_addr, ee_wdata} = {1'b1, w, a, d};
      @(negedge clock_in);
      ee_req = 1'b0;
      chk("ee_ack", {15'h0, ack}, 16'h0001);
      q = erd;
   endtask
   initial begin
      repeat (10) @(negedge clock_in);
      srst_in = 1'b0;
      u_rac_host_model.rd(16'h0100, q);
      chk("buf_rst", q, 16'h0000);
      u_rac_host_model.wr16(16'h0100, 16'h2211);
      chk("act_pre", act[15:0], 16'h0000);
      u_rac_host_model.rd(16'h0101, q);
      chk("buf_hi", q, 16'h0022);
      u_rac_host_model.rd2(16'h0100, w);
      chk("burst", w, 16'h2211);
      u_rac_host_model.wr(`RAC_UPD_ADDR, 8'h02);
      chk("act_badcmd", act[15:0], 16'h0000);
      chk("upd_badcmd", n_upd[15:0], 16'h0000);
      u_rac_host_model.wr(`RAC_UPD_ADDR, `RAC_UPD_CMD);
      chk("act_commit", act[15:0], 16'h2211);
      chk("upd_pulse", n_upd[15:0], 16'h0001);
      u_rac_host_model.wr(16'h0A00, 8'h5A);
      chk("live", act[8*`RAC_IDX_LIVE +: 8], 16'h005A);
      // Holes and the byte past the map top read back zero
      foreach (holes[i]) begin
         u_rac_host_model.wr(holes[i], 8'h77);
         u_rac_host_model.rd(holes[i], q);
         chk("hole", q, 16'h0000);
      end
      u_rac_host_model.wr(16'h0E3C, 8'hC3);
      u_rac_host_model.rd(16'h0E3C, q);
      chk("map_top", q, 16'h00C3);
      status = 32'h4433_2211;
      ee_busy = 1'b1;
      u_rac_host_model.rd(16'h0D02, q);
      chk("ro_busy", q, 16'h0033);
      u_rac_host_model.wr(16'h0D02, 8'h00);
      u_rac_host_model.rd(16'h0D02, q);
      chk("ro_wr", q, 16'h0033);
      u_rac_host_model.rd(16'h0100, q);
      chk("host_busy", q, 16'h0000);
      u_rac_host_model.wr(16'h0101, 8'h99);
      ee(1'b1, 16'h0102, 8'h9C);
      ee(1'b0, 16'h0102, 8'h00);
      chk("ee_rd", q, 16'h009C);
      // Excluded, read-only and trigger bytes are closed to the controller;
      // every one but the trigger holds a nonzero byte, and the trigger decodes onto nonzero active byte 0, so a leak would show
      foreach (shut[i]) begin
         ee(1'b0, shut[i], 8'h00);
         chk("ee_deny", q, 16'h0000);
      end
      ee(1'b1, 16'h0A01, 8'h66);
      chk("ee_live", act[8*(`RAC_IDX_LIVE+1) +: 8], 16'h0000);
      ee_busy = 1'b0;
      ee(1'b0, 16'h0100, 8'h00);
      chk("ee_idle", q, 16'h0000);
      u_rac_host_model.rd(16'h0101, q);
      chk("busy_drop", q, 16'h0022);
      u_rac_host_model.wr(16'h0E00, 8'h03);
      u_rac_host_model.wr(`RAC_UPD_ADDR, `RAC_UPD_CMD);
      chk("ac_set", act[8*`RAC_IDX_AC +: 8], 16'h0003);
      chk("upd_twice", n_upd[15:0], 16'h0002);
      done = 8'h01;
      repeat (2) @(negedge clock_in);
      chk("ac_clr", act[8*`RAC_IDX_AC +: 8], 16'h0002);
      done = 8'h00;
      u_rac_host_model.rd(16'h0E00, q);
      chk("ac_rd", q, 16'h0002);
      conclude();
   end
   // Limit well above the roughly 330 cycles the tests need
   initial begin
      repeat (6000) @(posedge clock_in);
      fails++;
      conclude();
   end
endmodule
`default_nettype wire
